// File: pos_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module pos_ctrl_model
(
  // clock
  input wire logic i_clk,
  // register access
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic o_double,
  output logic [31:0] o_wdata
);
  // ==========================================================
  // request driver, one request per falling edge
  initial
  begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_double = 1'b0;
    o_wdata = 32'h0000_0000;
  end
  // held a full cycle so the rising edge samples a settled request
  task automatic req(input logic w, input logic d, input logic [15:0] a,
    input logic [31:0] v);
    @(negedge i_clk);
    o_wr = w;
    o_rd = !w;
    o_double = d;
    o_addr = a;
    o_wdata = w ? v : ~o_wdata;
  endtask
  // released lines flip so a stale value never reads as valid
  task automatic idle();
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
endmodule
`default_nettype wire

// File: pos_regs_pkg.sv
package pos_regs_pkg;
  // ==========================================================
  // register numbers (word addresses, lower word at even)
  localparam logic [15:0] CUR_UNITS_X_ADDR = 16'h232C; // 9004
  localparam logic [15:0] CUR_UNITS_Y_ADDR = 16'h2336; // 9014
  localparam logic [15:0] CUR_PULSES_X_ADDR = 16'h2372; // 9074
  localparam logic [15:0] CUR_PULSES_Y_ADDR = 16'h2386; // 9094
  localparam logic [15:0] PARAM_X_BASE = 16'h23F0; // 9200
  localparam logic [15:0] PARAM_Y_BASE = 16'h24B8; // 9400
  // ==========================================================
  // parameter table layout
  localparam int PARAM_COUNT = 22;
  localparam logic [15:0] PARAM_SPAN = 16'h002C; // two words each
  localparam logic [4:0] IDX_PULSES_PER_ROT = 5'h01;
  localparam logic [4:0] IDX_TRAVEL_PER_ROT = 5'h02;
  localparam logic [4:0] IDX_COMMAND_UNIT = 5'h03;
  localparam logic [4:0] IDX_INTERP_CONST = 5'h0A;
  localparam logic [4:0] IDX_ROTATION_DIR = 5'h0C;
  localparam int ROT_SIGN_BIT = 0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ==========================================================
  // conversion timing
  localparam logic [6:0] DIV_STEPS = 7'h40;
endpackage

// File: positioning_parameter_register_bank.sv
// How it works
// - in two-axis mode marked registers use X value, Y contents disregarded.
// - in two-axis mode marked registers store same data in X and Y.
// - current-position pair holds position in the selected command unit.
// - pulse position is read-only and follows the unit position automatically.
// - interpolation speed and radius use X pulses and travel per rotation.
// - only X interpolation time constant applies, Y copy ignored.
// - absolute detection applies rotation direction to current address sign.
// - parameters are consecutive pairs from X and Y bases, lower even.
// - single-axis variant treats Y parameter registers as unavailable.
`timescale 1ns/1ps
`default_nettype none
module positioning_parameter_register_bank
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register access
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_double,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_ack,
  output logic o_err,
  // operating state
  input wire logic i_two_axis_sim,
  input wire logic i_single_axis_variant,
  input wire logic i_ready,
  input wire logic i_auto_mode,
  input wire logic i_manual_operating_mode,
  input wire logic i_remain_wait,
  // motion and absolute detection, index 0 is X
  input wire logic [1:0] i_move_valid,
  input wire logic [63:0] i_move_delta,
  input wire logic [1:0] i_abs_detect,
  input wire logic [63:0] i_abs_value,
  // values used by the motion logic
  output logic [31:0] o_interp_pulses_per_rot,
  output logic [31:0] o_interp_travel_per_rot,
  output logic [31:0] o_interp_time_const,
  output logic [31:0] o_y_pulses_per_rot,
  output logic [31:0] o_y_travel_per_rot,
  output logic [1:0] o_pulse_busy
);
  // ==========================================================
  // address decode
  wire logic [15:0] off_x = i_addr - pos_regs_pkg::PARAM_X_BASE;
  wire logic [15:0] off_y = i_addr - pos_regs_pkg::PARAM_Y_BASE;
  wire logic hit_px = (i_addr >= pos_regs_pkg::PARAM_X_BASE) &&
    (off_x < pos_regs_pkg::PARAM_SPAN);
  wire logic hit_py = (i_addr >= pos_regs_pkg::PARAM_Y_BASE) &&
    (off_y < pos_regs_pkg::PARAM_SPAN);
  wire logic [4:0] pidx = hit_py ? off_y[5:1] : off_x[5:1];
  wire logic hit_param = hit_px || hit_py;
  wire logic y_blocked = hit_py && i_single_axis_variant;
  wire logic [15:0] addr_even = {i_addr[15:1], 1'b0};
  wire logic hit_ux = (addr_even == pos_regs_pkg::CUR_UNITS_X_ADDR);
  wire logic hit_uy = (addr_even == pos_regs_pkg::CUR_UNITS_Y_ADDR);
  wire logic hit_qx = (addr_even == pos_regs_pkg::CUR_PULSES_X_ADDR);
  wire logic hit_qy = (addr_even == pos_regs_pkg::CUR_PULSES_Y_ADDR);
  wire logic hit_units = hit_ux || hit_uy;
  wire logic hit_pulses = hit_qx || hit_qy;
  wire logic mapped = (hit_param && !y_blocked) || hit_units || hit_pulses;
  // double-word registers only take an aligned 32-bit write
  wire logic pair_ok = i_double && !i_addr[0];
  wire logic pos_write_window = i_ready && !i_remain_wait &&
    (i_auto_mode || i_manual_operating_mode);
  wire logic wr_param = i_wr && hit_param && !y_blocked && pair_ok;
  wire logic wr_units = i_wr && hit_units && pair_ok &&
    pos_write_window;
  wire logic wr_pulses = i_wr && hit_pulses;
  wire logic rd_ok = i_rd && mapped && (!i_double || !i_addr[0]);
  wire logic wr_ok = wr_param || wr_units;
  wire logic req = i_rd || i_wr;

  // ==========================================================
  // parameter store
  logic [31:0] param_reg [2][pos_regs_pkg::PARAM_COUNT];
  logic [31:0] units_reg [2];
  logic [31:0] pulses [2];
  logic [1:0] units_changed_reg;
  logic [1:0] conv_done;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int a = 0; a < 2; a++)
      begin
        for (int p = 0; p < pos_regs_pkg::PARAM_COUNT; p++)
        begin
          param_reg[a][p] <= pos_regs_pkg::REG_RESET;
        end
      end
    end
    else if (wr_param)
    begin
      param_reg[hit_py][pidx] <= i_wdata;
    end
  end

  // ==========================================================
  // effective parameters
  assign o_interp_pulses_per_rot =
    param_reg[0][pos_regs_pkg::IDX_PULSES_PER_ROT];
  assign o_interp_travel_per_rot =
    param_reg[0][pos_regs_pkg::IDX_TRAVEL_PER_ROT];
  assign o_interp_time_const =
    param_reg[0][pos_regs_pkg::IDX_INTERP_CONST];
  assign o_y_pulses_per_rot = i_two_axis_sim ?
    param_reg[0][pos_regs_pkg::IDX_PULSES_PER_ROT] :
    param_reg[1][pos_regs_pkg::IDX_PULSES_PER_ROT];
  assign o_y_travel_per_rot = i_two_axis_sim ?
    param_reg[0][pos_regs_pkg::IDX_TRAVEL_PER_ROT] :
    param_reg[1][pos_regs_pkg::IDX_TRAVEL_PER_ROT];

  // ==========================================================
  // per-axis position and pulse conversion
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : axis
      wire logic mine = (g == 0) ? hit_ux : hit_uy;
      // the y copy follows x writes in simultaneous mode
      wire logic wr_me = wr_units &&
        (mine || ((g == 1) && i_two_axis_sim && hit_ux));
      wire logic [31:0] rot_dir =
        param_reg[g][pos_regs_pkg::IDX_ROTATION_DIR];
      wire logic [31:0] abs_in = i_abs_value[g*32 +: 32];
      wire logic [31:0] abs_signed = rot_dir[pos_regs_pkg::ROT_SIGN_BIT] ?
        32'(-abs_in) : abs_in;
      wire logic [31:0] ppr = (g == 1) ? o_y_pulses_per_rot :
        param_reg[0][pos_regs_pkg::IDX_PULSES_PER_ROT];
      wire logic [31:0] tpr = (g == 1) ? o_y_travel_per_rot :
        param_reg[0][pos_regs_pkg::IDX_TRAVEL_PER_ROT];
      wire logic [31:0] units_next = wr_me ? i_wdata :
        i_abs_detect[g] ? abs_signed :
        i_move_valid[g] ? units_reg[g] + i_move_delta[g*32 +: 32] :
        units_reg[g];

      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          units_reg[g] <= pos_regs_pkg::REG_RESET;
          units_changed_reg[g] <= 1'b0;
        end
        else
        begin
          units_reg[g] <= units_next;
          units_changed_reg[g] <= (units_next != units_reg[g]);
        end
      end

      unit_to_pulse_converter conv
      (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(units_changed_reg[g]),
        .i_units(units_reg[g]),
        .i_pulses_per_rot(ppr),
        .i_travel_per_rot(tpr),
        .o_pulses(pulses[g]),
        .o_busy(o_pulse_busy[g]),
        .o_done(conv_done[g])
      );
    end
  endgenerate

  // ==========================================================
  // read selection, 16-bit reads return the addressed word
  wire logic [31:0] pair_sel = hit_param ? param_reg[hit_py][pidx] :
    hit_ux ? units_reg[0] :
    hit_uy ? units_reg[1] :
    hit_qx ? pulses[0] :
    pulses[1];
  wire logic [31:0] word_sel = i_addr[0] ? {16'h0000, pair_sel[31:16]} :
    {16'h0000, pair_sel[15:0]};
  wire logic [31:0] read_value = i_double ? pair_sel : word_sel;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 32'h0000_0000;
      o_ack <= 1'b0;
      o_err <= 1'b0;
    end
    else
    begin
      o_ack <= req;
      // refused writes leave storage untouched and only flag here
      o_err <= req && !(i_rd ? rd_ok : wr_ok);
      if (rd_ok)
      begin
        o_rdata <= read_value;
      end
    end
  end

  // ==========================================================
  // checks
  chk_ro_write_refused: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_pulses |=> o_ack && o_err)
    else $error("read-only write not refused");

  chk_y_mirror_x: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_units && hit_ux && i_two_axis_sim
    |=> units_reg[1] == units_reg[0])
    else $error("y position not mirrored");

  chk_pos_write_stored: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_units && hit_ux
    |=> units_reg[0] == $past(i_wdata))
    else $error("position write lost");

  chk_pos_window_gate: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_wr && hit_ux && !pos_write_window &&
    !i_abs_detect[0] && !i_move_valid[0] |=> $stable(units_reg[0]) && o_err)
    else $error("position written outside window");

  chk_word_write_refused: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_wr && hit_uy && !i_double &&
    !i_two_axis_sim && !i_abs_detect[1] && !i_move_valid[1]
    |=> $stable(units_reg[1]))
    else $error("16-bit position write took effect");

  chk_pulse_follow: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) units_changed_reg[0] && !i_move_valid[0] &&
    !i_abs_detect[0] && !wr_units |-> ##[1:70] conv_done[0])
    else $error("pulse position did not follow");

  chk_y_uses_x: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_two_axis_sim
    |-> o_y_pulses_per_rot == param_reg[0][pos_regs_pkg::IDX_PULSES_PER_ROT])
    else $error("y axis not using x value");

  chk_interp_x_only: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_param && hit_py
    |=> $stable(o_interp_time_const))
    else $error("y time constant leaked");

  chk_abs_sign: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_abs_detect[0] && !wr_units &&
    param_reg[0][pos_regs_pkg::IDX_ROTATION_DIR][pos_regs_pkg::ROT_SIGN_BIT]
    |=> units_reg[0] == 32'(-$past(i_abs_value[31:0])))
    else $error("absolute sign not applied");

  chk_param_readback: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_rd && i_double &&
    i_addr == pos_regs_pkg::PARAM_X_BASE + 16'h0002
    |=> o_rdata == $past(param_reg[0][1]))
    else $error("parameter pair misplaced");

  chk_single_axis_y: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) req && hit_py && i_single_axis_variant
    |=> o_err)
    else $error("y parameter reachable on single axis");

  chk_interp_ppr: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_param && !hit_py &&
    pidx == pos_regs_pkg::IDX_PULSES_PER_ROT
    |=> o_interp_pulses_per_rot == $past(i_wdata))
    else $error("interpolation not using x pulses");

  chk_interp_tpr: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_param && !hit_py &&
    pidx == pos_regs_pkg::IDX_TRAVEL_PER_ROT
    |=> o_interp_travel_per_rot == $past(i_wdata))
    else $error("interpolation not using x travel");

  chk_y_travel_x: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_two_axis_sim
    |-> o_y_travel_per_rot == param_reg[0][pos_regs_pkg::IDX_TRAVEL_PER_ROT])
    else $error("y travel not using x value");

  chk_ack_follows: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) req |=> o_ack)
    else $error("request not acknowledged");

  chk_no_stray_ack: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) !req |=> !o_ack)
    else $error("acknowledge without request");

  chk_err_with_ack: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) o_err |-> o_ack)
    else $error("error without acknowledge");

  chk_odd_write_refused: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_wr && !i_rd && i_addr[0] |=> o_err)
    else $error("odd address write accepted");

  chk_half_write_refused: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_wr && !i_rd && !i_double |=> o_err)
    else $error("16-bit write accepted");

  chk_unmapped_refused: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) req && !mapped |=> o_err)
    else $error("unmapped access accepted");

  chk_rdata_holds: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) !rd_ok |=> $stable(o_rdata))
    else $error("read data changed without read");

  chk_pulse_untouched: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_pulses && hit_qx && !o_pulse_busy[0] &&
    !units_changed_reg[0] |=> $stable(pulses[0]))
    else $error("pulse position written");

  chk_conv_starts: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) units_changed_reg[0] &&
    param_reg[0][pos_regs_pkg::IDX_TRAVEL_PER_ROT] != 32'h0000_0000
    |=> o_pulse_busy[0])
    else $error("pulse conversion not started");

  chk_y_pos_stored: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_units && hit_uy
    |=> units_reg[1] == $past(i_wdata))
    else $error("y position write lost");

  chk_y_param_stored: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) wr_param && hit_py
    |=> param_reg[1][$past(pidx)] == $past(i_wdata))
    else $error("y parameter pair misplaced");

  chk_abs_plain: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_abs_detect[0] && !wr_units &&
    !param_reg[0][pos_regs_pkg::IDX_ROTATION_DIR][pos_regs_pkg::ROT_SIGN_BIT]
    |=> units_reg[0] == $past(i_abs_value[31:0]))
    else $error("absolute value altered");
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // signals
  logic i_clk, i_rst_n, i_two_axis_sim, i_single_axis_variant;
  logic i_ready, i_auto_mode, i_manual_operating_mode, i_remain_wait;
  logic [1:0] i_move_valid, i_abs_detect, o_pulse_busy;
  logic [63:0] i_move_delta, i_abs_value;
  logic [15:0] bus_addr;
  logic bus_wr, bus_rd, bus_double, o_ack, o_err;
  logic [31:0] bus_wdata, o_rdata, seed;
  logic [31:0] o_interp_pulses_per_rot, o_interp_travel_per_rot;
  logic [31:0] o_interp_time_const, o_y_pulses_per_rot, o_y_travel_per_rot;
  logic [31:0] pv [0:43];
  logic [33:0] exp_q [$];
  logic [33:0] note;
  int err_total, checked;
  // ==========================================================
  // instances
  pos_ctrl_model i_pos_ctrl_model (.i_clk(i_clk), .o_addr(bus_addr),
    .o_wr(bus_wr), .o_rd(bus_rd), .o_double(bus_double),
    .o_wdata(bus_wdata));
  positioning_parameter_register_bank i_positioning_parameter_register_bank
  (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(bus_addr), .i_wr(bus_wr),
    .i_rd(bus_rd), .i_double(bus_double), .i_wdata(bus_wdata),
    .o_rdata(o_rdata), .o_ack(o_ack), .o_err(o_err),
    .i_two_axis_sim(i_two_axis_sim),
    .i_single_axis_variant(i_single_axis_variant), .i_ready(i_ready),
    .i_auto_mode(i_auto_mode),
    .i_manual_operating_mode(i_manual_operating_mode),
    .i_remain_wait(i_remain_wait), .i_move_valid(i_move_valid),
    .i_move_delta(i_move_delta), .i_abs_detect(i_abs_detect),
    .i_abs_value(i_abs_value),
    .o_interp_pulses_per_rot(o_interp_pulses_per_rot),
    .o_interp_travel_per_rot(o_interp_travel_per_rot),
    .o_interp_time_const(o_interp_time_const),
    .o_y_pulses_per_rot(o_y_pulses_per_rot),
    .o_y_travel_per_rot(o_y_travel_per_rot), .o_pulse_busy(o_pulse_busy)
  );
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // each request notes {check data, refused, data}
  task automatic wr(input logic [15:0] a, input logic [31:0] v,
    input logic e, input logic d = 1'b1);
    exp_q.push_back({1'b0, e, 32'h0000_0000});
    i_pos_ctrl_model.req(1'b1, d, a, v);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x,
    input logic e, input logic d = 1'b1);
    exp_q.push_back({!e, e, e ? 32'h0000_0000 : x});
    i_pos_ctrl_model.req(1'b0, d, a, 32'h0000_0000);
  endtask
  task automatic gap(input int n);
    i_pos_ctrl_model.idle();
    repeat (n) @(negedge i_clk);
  endtask
  task automatic tally_and_finish();
    if (exp_q.size() != 0)
      err_total++;
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, result monitor
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    #50000;
    err_total++;
    tally_and_finish();
  end
  always @(negedge i_clk)
  begin
    if (o_ack === 1'b1)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
      cmp({o_err, note[33] ? o_rdata : 32'h0000_0000}, note[32:0]);
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    {i_rst_n, i_two_axis_sim, i_single_axis_variant, i_remain_wait} = 4'h0;
    {i_ready, i_auto_mode, i_manual_operating_mode} = 3'h0;
    {i_move_valid, i_abs_detect} = 4'h0;
    i_move_delta = 64'h0;
    i_abs_value = 64'h0;
    err_total = 0;
    checked = 0;
    seed = 32'h1F73;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(pos_regs_pkg::PARAM_X_BASE, 32'h0000_0000, 1'b0);
    rd(pos_regs_pkg::CUR_PULSES_X_ADDR, 32'h0000_0000, 1'b0);
    // every parameter pair on both axes, back to back
    for (int i = 0; i < 44; i++)
    begin
      seed = lfsr(seed);
      pv[i] = seed;
      wr((i < 22 ? pos_regs_pkg::PARAM_X_BASE : pos_regs_pkg::PARAM_Y_BASE)
        + 16'((i % 22) * 2), seed, 1'b0);
    end
    for (int i = 0; i < 44; i++)
      rd((i < 22 ? pos_regs_pkg::PARAM_X_BASE : pos_regs_pkg::PARAM_Y_BASE)
        + 16'((i % 22) * 2), pv[i], 1'b0);
    wr(pos_regs_pkg::CUR_PULSES_X_ADDR, 32'hA5A5_5A5A, 1'b1);
    rd(pos_regs_pkg::CUR_PULSES_X_ADDR, 32'h0000_0000, 1'b0);
    wr(pos_regs_pkg::PARAM_X_BASE, 32'h1234_5678, 1'b1, 1'b0);
    rd(pos_regs_pkg::PARAM_X_BASE, {16'h0, pv[0][15:0]}, 1'b0, 1'b0);
    rd(pos_regs_pkg::PARAM_X_BASE + 16'h1, {16'h0, pv[0][31:16]}, 1'b0,
      1'b0);
    rd(pos_regs_pkg::PARAM_X_BASE + 16'h1, 32'h0, 1'b1);
    rd(16'h0000, 32'h0, 1'b1);
    wr(pos_regs_pkg::PARAM_X_BASE + 16'h2, 32'h0000_0010, 1'b0);
    wr(pos_regs_pkg::PARAM_X_BASE + 16'h4, 32'h0000_0004, 1'b0);
    gap(2);
    cmp({1'b0, o_interp_pulses_per_rot}, 33'h0_0000_0010);
    cmp({1'b0, o_interp_travel_per_rot}, 33'h0_0000_0004);
    cmp({1'b0, o_interp_time_const}, {1'b0, pv[10]});
    cmp({1'b0, o_y_pulses_per_rot}, {1'b0, pv[23]});
    // position write window
    i_ready = 1'b1;
    i_manual_operating_mode = 1'b1;
    i_remain_wait = 1'b1;
    wr(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'h0000_0064, 1'b1);
    gap(1);
    i_remain_wait = 1'b0;
    wr(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'h0000_0064, 1'b0);
    rd(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'h0000_0064, 1'b0);
    gap(4);
    cmp({32'h0000_0000, o_pulse_busy[0]}, 33'h0_0000_0001);
    for (int k = 0; k < 200 && o_pulse_busy[0] !== 1'b0; k++)
      @(negedge i_clk);
    rd(pos_regs_pkg::CUR_PULSES_X_ADDR, 32'h0000_0190, 1'b0);
    gap(1);
    // simultaneous two-axis mode
    i_two_axis_sim = 1'b1;
    i_manual_operating_mode = 1'b0;
    i_auto_mode = 1'b1;
    @(negedge i_clk);
    cmp({1'b0, o_y_pulses_per_rot}, 33'h0_0000_0010);
    cmp({1'b0, o_y_travel_per_rot}, 33'h0_0000_0004);
    wr(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'h0000_0007, 1'b0);
    rd(pos_regs_pkg::CUR_UNITS_Y_ADDR, 32'h0000_0007, 1'b0);
    gap(1);
    i_two_axis_sim = 1'b0;
    // absolute load with reversed direction, then a move
    wr(pos_regs_pkg::PARAM_X_BASE + 16'h18, 32'h0000_0001, 1'b0);
    gap(1);
    i_abs_value = 64'h0000_0000_0000_0005;
    i_abs_detect = 2'h1;
    @(negedge i_clk);
    i_abs_detect = 2'h0;
    rd(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'hFFFF_FFFB, 1'b0);
    gap(1);
    i_move_delta = 64'h0000_0000_0000_0003;
    i_move_valid = 2'h1;
    @(negedge i_clk);
    i_move_valid = 2'h0;
    rd(pos_regs_pkg::CUR_UNITS_X_ADDR, 32'hFFFF_FFFE, 1'b0);
    // single-axis variant hides the Y table
    gap(1);
    i_single_axis_variant = 1'b1;
    rd(pos_regs_pkg::PARAM_Y_BASE, 32'h0, 1'b1);
    wr(pos_regs_pkg::PARAM_Y_BASE, 32'h0000_0001, 1'b1);
    gap(1);
    i_single_axis_variant = 1'b0;
    rd(pos_regs_pkg::PARAM_Y_BASE, pv[22], 1'b0);
    gap(4);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: unit_to_pulse_converter.sv
`timescale 1ns/1ps
`default_nettype none
module unit_to_pulse_converter
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request
  input wire logic i_start,
  input wire logic [31:0] i_units,
  input wire logic [31:0] i_pulses_per_rot,
  input wire logic [31:0] i_travel_per_rot,
  // result
  output logic [31:0] o_pulses,
  output logic o_busy,
  output logic o_done
);
  typedef enum logic {IDLE = 1'b0, DIVIDE = 1'b1} conv_state_type;
  // ==========================================================
  // start terms
  wire logic neg_in = i_units[31];
  wire logic [31:0] mag_in = neg_in ? 32'(-i_units) : i_units;
  wire logic [63:0] product = 64'(mag_in) * 64'(i_pulses_per_rot);
  wire logic no_travel = (i_travel_per_rot == 32'h0000_0000);
  // ==========================================================
  // restoring divider, one quotient bit a cycle
  conv_state_type state_reg;
  logic [63:0] dvd_reg;
  logic [32:0] rem_reg;
  logic [31:0] div_reg;
  logic [6:0] cnt_reg;
  logic neg_reg;
  wire logic [32:0] rem_shift = {rem_reg[31:0], dvd_reg[63]};
  wire logic fits = (rem_shift >= {1'b0, div_reg});
  wire logic [32:0] rem_sub = rem_shift - {1'b0, div_reg};
  wire logic last_step = (cnt_reg == pos_regs_pkg::DIV_STEPS - 7'h01);
  wire logic [31:0] quot_next = {dvd_reg[30:0], fits};
  assign o_busy = (state_reg == DIVIDE);

  always_ff @(posedge i_clk)
  begin
    o_done <= 1'b0;
    if (!i_rst_n)
    begin
      state_reg <= IDLE;
      dvd_reg <= 64'h0;
      rem_reg <= 33'h0;
      div_reg <= 32'h0;
      cnt_reg <= 7'h00;
      neg_reg <= 1'b0;
      o_pulses <= 32'h0;
    end
    else if (i_start && no_travel)
    begin
      // a zero divisor leaves the unit value unscaled
      state_reg <= IDLE;
      o_pulses <= i_units;
      o_done <= 1'b1;
    end
    else if (i_start)
    begin
      // a new value restarts any conversion in flight
      state_reg <= DIVIDE;
      dvd_reg <= product;
      rem_reg <= 33'h0;
      div_reg <= i_travel_per_rot;
      cnt_reg <= 7'h00;
      neg_reg <= neg_in;
    end
    else
    begin
      case (state_reg)
        DIVIDE:
        begin
          dvd_reg <= {dvd_reg[62:0], fits};
          rem_reg <= fits ? rem_sub : rem_shift;
          cnt_reg <= cnt_reg + 7'h01;
          if (last_step)
          begin
            state_reg <= IDLE;
            o_pulses <= neg_reg ? 32'(-quot_next) : quot_next;
            o_done <= 1'b1;
          end
        end
        default:
          state_reg <= IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire
